/* src/pmc_defs.svh */
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_CFG_RESET 16'h0061
`define PMC_CFG_USED_MASK 16'h007f
`define PMC_EN_BIT 6
`define PMC_MODE_HI 5
`define PMC_MODE_LO 4
`define PMC_GAIN_HI 3
`define PMC_GAIN_LO 2
`define PMC_ATTEN_HI 1
`define PMC_ATTEN_LO 0
`define PMC_GC_ENABLE 8'h81
`define PMC_GC_DISABLE 8'h82
`define PMC_SETTLE_US 40
`define PMC_CLK_MHZ 25
`define PMC_SETTLE_CYCLES (`PMC_SETTLE_US * `PMC_CLK_MHZ)
// Product scale factor in thousandths, index {atten, gain}
`define PMC_PSF_A0_G0 16'h0a6b
`define PMC_PSF_A0_G1 16'h42ab
`define PMC_PSF_A0_G2 16'h9c40
`define PMC_PSF_A1_G0 16'h0535
`define PMC_PSF_A1_G1 16'h2155
`define PMC_PSF_A1_G2 16'h4e20
`define PMC_PSF_A2_G0 16'h029b
`define PMC_PSF_A2_G1 16'h10ab
`define PMC_PSF_A2_G2 16'h2710
`define PMC_PSF_UNDEF 16'h0000
`endif

/* src/pmc_pkg.sv */
package pmc_pkg;
    typedef enum logic [1:0] {
        PMC_OUT_BUS_V,
        PMC_OUT_SHUNT_V,
        PMC_OUT_SUPPLY_P,
        PMC_OUT_LOAD_P
    } pmc_mode_e;
    typedef enum logic [2:0] {
        PMC_W_IDLE,
        PMC_W_HI,
        PMC_W_LO,
        PMC_W_GC,
        PMC_W_SKIP
    } pmc_wphase_e;
endpackage

/* src/pmc_settle_timer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defs.svh"
module pmc_settle_timer
(
    input wire logic clk,
    input wire logic reset,
    input wire logic enabled,
    output logic settled
);
    import pmc_pkg::*;
    localparam logic [9:0] SETTLE_LAST = 10'(`PMC_SETTLE_CYCLES - 1);
    logic [9:0] count;

    // Restart settling whenever the device is disabled
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            count <= 10'h000;
            settled <= 1'b0;
        end
        else if (!enabled)
        begin
            count <= 10'h000;
            settled <= 1'b0;
        end
        else if (!settled)
        begin
            if (count == SETTLE_LAST)
            begin
                settled <= 1'b1;
            end
            count <= count + 10'h001;
        end
    end
endmodule
`default_nettype wire

/* src/pmc_config_reg.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defs.svh"
module pmc_config_reg
(
    input wire logic clk,
    input wire logic reset,
    input wire logic frame_start,
    input wire logic general_call,
    input wire logic wr_byte_valid,
    input wire logic [7:0] wr_byte,
    input wire logic frame_stop,
    input wire logic rd_byte_req,
    output logic [7:0] rd_byte,
    output logic [15:0] monitor_configuration,
    output logic device_enabled,
    output logic output_valid,
    output var pmc_pkg::pmc_mode_e output_select,
    output logic bus_sense_load_side,
    output logic [1:0] shunt_gain_code,
    output logic [1:0] bus_atten_code,
    output logic [15:0] product_scale_factor
);
    import pmc_pkg::*;

    pmc_wphase_e wphase;
    logic [7:0] hi_byte;
    logic rd_lo_next;
    logic settled;
    logic [15:0] next_cfg;
    logic [15:0] next_psf;
    pmc_mode_e next_mode;

    // Next register value from data writes and general calls
    always_comb
    begin
        next_cfg = monitor_configuration;
        if (wr_byte_valid && wphase == PMC_W_LO)
        begin
            next_cfg = {hi_byte, wr_byte} & `PMC_CFG_USED_MASK;
        end
        else if (wr_byte_valid && wphase == PMC_W_GC)
        begin
            if (wr_byte == `PMC_GC_ENABLE)
            begin
                next_cfg[`PMC_EN_BIT] = 1'b1;
            end
            else if (wr_byte == `PMC_GC_DISABLE)
            begin
                next_cfg[`PMC_EN_BIT] = 1'b0;
            end
        end
    end

    assign next_mode = pmc_mode_e'(next_cfg[`PMC_MODE_HI:`PMC_MODE_LO]);

    // Factor used by the analog multiplier in the power modes
    always_comb
    begin
        case ({next_cfg[`PMC_ATTEN_HI:`PMC_ATTEN_LO],
               next_cfg[`PMC_GAIN_HI:`PMC_GAIN_LO]})
            4'h0: next_psf = `PMC_PSF_A0_G0;
            4'h1: next_psf = `PMC_PSF_A0_G1;
            4'h2: next_psf = `PMC_PSF_A0_G2;
            4'h4: next_psf = `PMC_PSF_A1_G0;
            4'h5: next_psf = `PMC_PSF_A1_G1;
            4'h6: next_psf = `PMC_PSF_A1_G2;
            4'h8: next_psf = `PMC_PSF_A2_G0;
            4'h9: next_psf = `PMC_PSF_A2_G1;
            4'ha: next_psf = `PMC_PSF_A2_G2;
            default: next_psf = `PMC_PSF_UNDEF;
        endcase
    end

    // Byte sequencing within a write frame
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wphase <= PMC_W_IDLE;
        end
        else if (frame_stop)
        begin
            wphase <= PMC_W_IDLE;
        end
        else if (frame_start)
        begin
            wphase <= general_call ? PMC_W_GC : PMC_W_HI;
        end
        else if (wr_byte_valid)
        begin
            case (wphase)
                PMC_W_HI: wphase <= PMC_W_LO;
                PMC_W_LO: wphase <= PMC_W_SKIP;
                PMC_W_GC: wphase <= PMC_W_SKIP;
                PMC_W_SKIP: wphase <= PMC_W_SKIP;
                default: wphase <= PMC_W_IDLE;
            endcase
        end
    end

    // Most significant byte held until the low byte arrives
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            hi_byte <= 8'h00;
        end
        else if (wr_byte_valid && wphase == PMC_W_HI)
        begin
            hi_byte <= wr_byte;
        end
    end

    // Register and its decoded controls
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            monitor_configuration <= `PMC_CFG_RESET;
            device_enabled <= 1'b1;
            output_select <= PMC_OUT_SUPPLY_P;
            bus_sense_load_side <= 1'b0;
            shunt_gain_code <= 2'h0;
            bus_atten_code <= 2'h1;
            product_scale_factor <= `PMC_PSF_A1_G0;
        end
        else
        begin
            monitor_configuration <= next_cfg;
            device_enabled <= next_cfg[`PMC_EN_BIT];
            output_select <= next_mode;
            bus_sense_load_side <= (next_mode == PMC_OUT_LOAD_P);
            shunt_gain_code <= next_cfg[`PMC_GAIN_HI:`PMC_GAIN_LO];
            bus_atten_code <= next_cfg[`PMC_ATTEN_HI:`PMC_ATTEN_LO];
            product_scale_factor <= next_psf;
        end
    end

    // Read data, high byte first
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rd_byte <= 8'h00;
            rd_lo_next <= 1'b0;
        end
        else if (frame_start)
        begin
            rd_lo_next <= 1'b0;
        end
        else if (rd_byte_req)
        begin
            rd_byte <= rd_lo_next ? monitor_configuration[7:0]
                                  : monitor_configuration[15:8];
            rd_lo_next <= !rd_lo_next;
        end
    end

    pmc_settle_timer u_settle
    (
        .clk(clk),
        .reset(reset),
        .enabled(device_enabled),
        .settled(settled)
    );

    // Valid output registered from enabled and settled, so it follows them one cycle later
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            output_valid <= 1'b0;
        end
        else
        begin
            output_valid <= device_enabled && settled;
        end
    end

    // Cycles spent enabled, saturating, for the settling check
    logic [10:0] en_age;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            en_age <= 11'h000;
        end
        else if (!device_enabled)
        begin
            en_age <= 11'h000;
        end
        else if (en_age != 11'h7ff)
        begin
            en_age <= en_age + 11'h001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_disable_kills_valid: assert property (
        !device_enabled |=> !output_valid)
        else $error("output valid while disabled");
    a_enable_follows_bit: assert property (
        device_enabled == monitor_configuration[`PMC_EN_BIT])
        else $error("enable state differs from register bit");
    a_settle_not_early: assert property (
        $rose(device_enabled) |-> !output_valid [*8])
        else $error("output valid before settling");
    a_settle_bounded: assert property (
        en_age >= 11'(`PMC_SETTLE_CYCLES + 1) |-> output_valid)
        else $error("output not valid after settling");
    a_gc_disable: assert property (
        wr_byte_valid && wphase == PMC_W_GC && wr_byte == 8'h82
        && !frame_stop |=> !device_enabled)
        else $error("general-call disable ignored");
    a_gc_enable: assert property (
        wr_byte_valid && wphase == PMC_W_GC && wr_byte == 8'h81
        && !frame_stop |=> device_enabled)
        else $error("general-call enable ignored");
    a_mode_mux: assert property (
        output_select == pmc_mode_e'(monitor_configuration[5:4]))
        else $error("mux select differs from mode field");
    a_sense_side: assert property (
        bus_sense_load_side == (monitor_configuration[5:4] == 2'h3))
        else $error("bus sense side wrong");
    a_bus_mode_supply: assert property (
        output_select == PMC_OUT_BUS_V |-> !bus_sense_load_side)
        else $error("bus mode not on supply side");
    a_write_msb_first: assert property (
        wr_byte_valid && wphase == PMC_W_HI && !frame_stop && !frame_start
        ##1 wr_byte_valid && wphase == PMC_W_LO && !frame_stop
        && !frame_start |=> monitor_configuration ==
        ({$past(wr_byte, 2), $past(wr_byte)} & 16'h007f))
        else $error("two-byte write not stored msb first");
    a_scale_max: assert property (
        shunt_gain_code == 2'h2 && bus_atten_code == 2'h0
        |-> product_scale_factor == 16'h9c40)
        else $error("product factor wrong");
endmodule
`default_nettype wire

/* verif/pmc_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pmc_master_model
(
    input wire logic clk,
    input wire logic [7:0] rd_byte,
    output logic frame_start,
    output logic general_call,
    output logic wr_byte_valid,
    output logic [7:0] wr_byte,
    output logic frame_stop,
    output logic rd_byte_req
);
    initial
    begin
        {frame_start, general_call, wr_byte_valid} = 3'h0;
        {frame_stop, rd_byte_req} = 2'h0;
        wr_byte = 8'h00;
    end
    // Frame start, n bytes high first, then stop
    task automatic send(input logic gc, input int n, input logic [15:0] d);
        @(posedge clk);
        frame_start <= 1'b1;
        general_call <= gc;
        @(posedge clk);
        frame_start <= 1'b0;
        general_call <= ~gc;
        for (int i = 0; i < n; i++)
        begin
            wr_byte_valid <= 1'b1;
            wr_byte <= (i == 0) ? d[15:8] : d[7:0];
            @(posedge clk);
        end
        wr_byte_valid <= 1'b0;
        wr_byte <= ~wr_byte;
        @(posedge clk);
        frame_stop <= 1'b1;
        @(posedge clk);
        frame_stop <= 1'b0;
    endtask
    // Read frame, two byte requests back to back
    task automatic read(output logic [15:0] v);
        @(posedge clk);
        frame_start <= 1'b1;
        general_call <= 1'b0;
        @(posedge clk);
        frame_start <= 1'b0;
        rd_byte_req <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        v[15:8] = rd_byte;
        rd_byte_req <= 1'b0;
        @(posedge clk);
        v[7:0] = rd_byte;
        frame_stop <= 1'b1;
        @(posedge clk);
        frame_stop <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* verif/power_monitor_config_register_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module power_monitor_config_register_tb_top;
    import pmc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    wire logic fs, gc, wv, fp, rq;
    wire logic [7:0] wb;
    logic [7:0] rb;
    logic [15:0] cfg, psf, v;
    logic en, ov, ls;
    pmc_mode_e sel;
    logic [1:0] gn, at;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    // Scale factor in thousandths, index [atten][gain]
    localparam logic [15:0] PSF_TAB [3][3] = '{
        '{16'h0a6b, 16'h42ab, 16'h9c40},
        '{16'h0535, 16'h2155, 16'h4e20},
        '{16'h029b, 16'h10ab, 16'h2710}};
    always #20 clk = ~clk;
    pmc_master_model i_master (.clk(clk), .rd_byte(rb), .frame_start(fs),
        .general_call(gc), .wr_byte_valid(wv), .wr_byte(wb),
        .frame_stop(fp), .rd_byte_req(rq));
    pmc_config_reg i_dut (.clk(clk), .reset(reset), .frame_start(fs),
        .general_call(gc), .wr_byte_valid(wv), .wr_byte(wb),
        .frame_stop(fp), .rd_byte_req(rq), .rd_byte(rb),
        .monitor_configuration(cfg), .device_enabled(en),
        .output_valid(ov), .output_select(sel),
        .bus_sense_load_side(ls), .shunt_gain_code(gn),
        .bus_atten_code(at), .product_scale_factor(psf));
    task automatic finish_test;
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            finish_test();
        end
    end
    task automatic wait_settle;
        int n;
        n = 0;
        while (ov !== 1'b1 && n < 1100)
        begin
            @(posedge clk);
            n++;
        end
        check("settle", 16'h1, 16'(n >= 990 && n <= 1002));
    endtask
    task automatic t_reset;
        check("cfg", 16'h0061, cfg);
        check("sel", 16'h2, 16'(sel));
        check("psf", 16'h0535, psf);
        check("valid", 16'h0, 16'(ov));
        wait_settle();
    endtask
    task automatic t_modes;
        logic [7:0] lo;
        for (int m = 0; m < 4; m++)
            for (int g = 0; g < 4; g++)
                for (int a = 0; a < 4; a++)
                begin
                    lo = {1'b1, 2'(m), 2'(g), 2'(a)};
                    i_master.send(1'b0, 2, {8'hff, lo});
                    check("cfg", {9'h0, lo[6:0]}, cfg);
                    check("sel", 16'(m), 16'(sel));
                    check("load", 16'(m == 3), 16'(ls));
                    check("gain", 16'(g), 16'(gn));
                    check("atten", 16'(a), 16'(at));
                    check("psf", (a == 3 || g == 3) ? 16'h0
                        : PSF_TAB[a][g], psf);
                end
        i_master.send(1'b0, 1, 16'h0000);
        check("short", 16'h007f, cfg);
    endtask
    task automatic t_enable;
        i_master.send(1'b0, 2, 16'h0021);
        check("en", 16'h0, 16'(en));
        check("valid", 16'h0, 16'(ov));
        i_master.send(1'b0, 2, 16'h0061);
        check("en", 16'h1, 16'(en));
        check("valid", 16'h0, 16'(ov));
        wait_settle();
        i_master.send(1'b1, 1, 16'h8200);
        check("gc", 16'h0021, cfg);
        check("valid", 16'h0, 16'(ov));
        i_master.send(1'b1, 1, 16'h0600);
        check("gc", 16'h0, 16'(en));
        i_master.send(1'b1, 1, 16'h8100);
        check("gc", 16'h0061, cfg);
        wait_settle();
    endtask
    task automatic t_read;
        i_master.send(1'b0, 2, 16'hab5a);
        i_master.read(v);
        check("read", 16'h005a, v);
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_modes();
        t_enable();
        t_read();
        finish_test();
    end
endmodule
`default_nettype wire
